// >>> rtl/timer8_params.svh
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

// Register byte offsets, one 32-bit word each
`define GTC_OFF        8'h00
`define CTRL_A_OFF     8'h04
`define CTRL_B_OFF     8'h08
`define COUNT_OFF      8'h0C
`define CMP_A_OFF      8'h10
`define CMP_B_OFF      8'h14
`define FLAG_OFF       8'h18
`define MASK_OFF       8'h1C
`define POWER_OFF      8'h20

// General timer control fields
`define GTC_SYNC_BIT   7
`define GTC_CAPSEL_BIT 6
`define GTC_DIVRST_BIT 0

// Control A fields
`define CA_COMA_HI     7
`define CA_COMA_LO     6
`define CA_COMB_HI     5
`define CA_COMB_LO     4
`define CA_WGM1_BIT    1
`define CA_WGM0_BIT    0

// Control B fields
`define CB_WGM2_BIT    3
`define CB_CS_HI       2
`define CB_CS_LO       0

// Flag and mask bit positions
`define FLAG_OVF       0
`define FLAG_CMPA      1
`define FLAG_CMPB      2

// Power control field
`define PWR_OFF_BIT    0

// Counter limits and reset values
`define CNT_BOTTOM     8'h00
`define CNT_MAX        8'hFF
`define REG_RESET      8'h00

`endif

// >>> rtl/timer8_pkg.sv
package timer8_pkg;

  // Waveform mode codes
  typedef enum logic [2:0] {
    WM_NORMAL    = 3'h0,
    WM_PHASE_MAX = 3'h1,
    WM_CTC       = 3'h2,
    WM_FAST_MAX  = 3'h3,
    WM_RSVD4     = 3'h4,
    WM_PHASE_OCA = 3'h5,
    WM_RSVD6     = 3'h6,
    WM_FAST_OCA  = 3'h7
  } wave_mode_t;

  // Clock select codes
  typedef enum logic [2:0] {
    CS_STOP   = 3'h0,
    CS_DIV1   = 3'h1,
    CS_DIV8   = 3'h2,
    CS_DIV64  = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1K  = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clk_sel_t;

endpackage : timer8_pkg

// >>> rtl/shared_prescaler.sv
`timescale 1ns/10ps
`default_nettype none

module shared_prescaler #(
  parameter int unsigned WIDTH = 10
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Divider hold
  input  wire logic       div_reset_i,
  // Tap strobes: /8, /64, /256, /1024
  output logic      [3:0] tap_o
);

  logic [WIDTH-1:0] cnt_q;

  // Free running divider, held at zero while reset is asserted
  always_ff @(posedge clk_i) begin
    if (rst_i || div_reset_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Registered one-cycle tap strobes
  always_ff @(posedge clk_i) begin
    if (rst_i || div_reset_i) begin
      tap_o <= 4'h0;
    end else begin
      tap_o <= {&cnt_q[9:0], &cnt_q[7:0], &cnt_q[5:0], &cnt_q[2:0]};
    end
  end

endmodule : shared_prescaler

`default_nettype wire

// >>> rtl/ext_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none

module ext_edge_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Asynchronous pin
  input  wire logic pin_i,
  // Edge strobes and synchronized level
  output logic      rise_o,
  output logic      fall_o,
  output logic      level_o
);

  logic meta_q;
  logic prev_q;

  // Two-flop synchronizer; first stage feeds only the second
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q  <= 1'b0;
      level_o <= 1'b0;
    end else begin
      meta_q  <= pin_i;
      level_o <= meta_q;
    end
  end

  // Edge detector on the synchronized level
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      prev_q <= level_o;
      rise_o <= level_o & ~prev_q;
      fall_o <= ~level_o & prev_q;
    end
  end

endmodule : ext_edge_sync

`default_nettype wire

// >>> rtl/timer8.sv
`timescale 1ns/10ps
`default_nettype none
`include "timer8_params.svh"

module timer8 #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  input  wire logic [31:0]       dat_i,
  input  wire logic [3:0]        sel_i,
  output logic      [31:0]       dat_o,
  output logic                   ack_o,
  // Pins
  input  wire logic              ext_count_pin_i,
  input  wire logic              capture_pin_primary_i,
  input  wire logic              capture_pin_alternate_i,
  output logic                   compare_out_a_o,
  output logic                   compare_out_a_en_o,
  output logic                   compare_out_b_o,
  output logic                   compare_out_b_en_o,
  // Links to the second timer
  output logic                   shared_divider_reset_o,
  output logic      [3:0]        prescale_tap_o,
  output logic                   capture_trigger_o,
  // Interrupt requests and acknowledges: overflow, compare A, compare B
  output logic      [2:0]        irq_o,
  input  wire logic [2:0]        irq_ack_i
);

  // Register state
  logic       sync_hold_mode_q;
  logic       capture_input_select_q;
  logic       shared_divider_reset_q;
  logic       div_reset_pulse_q;
  logic [7:0] timer_ctrl_a_q;
  logic [7:0] timer_ctrl_b_q;
  logic [7:0] count_value_q;
  logic [7:0] count_value_d;
  logic [7:0] cmp_a_q;
  logic [7:0] cmp_b_q;
  logic [7:0] cmp_a_buf_q;
  logic [7:0] cmp_b_buf_q;
  logic [2:0] timer_flag_q;
  logic [2:0] timer_irq_mask_q;
  logic       timer_power_off_q;
  logic       count_up_q;
  logic       count_up_d;
  logic       block_q;
  logic       oc_a_q;
  logic       oc_b_q;

  // Decoded controls
  timer8_pkg::wave_mode_t waveform_mode_field;
  timer8_pkg::clk_sel_t   clock_select_field;
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [7:0] top_val;
  logic       pwm;
  logic       phase;
  logic       timer_tick;
  logic       at_top;
  logic       ovf_evt;
  logic       match_a;
  logic       match_b;
  logic       wrap_evt;

  // Bus decode
  logic       req;
  logic       wr_en;
  logic [7:0] wbyte;
  logic [7:0] rd_val;

  // Pin side
  logic [3:0] tap;
  logic       ext_rise;
  logic       ext_fall;
  logic       cap_pri_meta_q;
  logic       cap_pri_q;
  logic       cap_alt_meta_q;
  logic       cap_alt_q;

  // True for the PWM waveform modes
  function automatic logic is_pwm(input timer8_pkg::wave_mode_t m);
    is_pwm = (m == timer8_pkg::WM_PHASE_MAX) || (m == timer8_pkg::WM_FAST_MAX) ||
             (m == timer8_pkg::WM_PHASE_OCA) || (m == timer8_pkg::WM_FAST_OCA);
  endfunction : is_pwm

  // Next compare output level for one unit
  function automatic logic wave_next(input logic [1:0] com, input logic pwm_m,
                                     input logic phase_m, input logic up,
                                     input logic match, input logic wrap,
                                     input logic oc);
    logic v;
    v = oc;
    if (!pwm_m) begin
      if (match) begin
        unique case (com)
          2'h1:    v = ~oc;
          2'h2:    v = 1'b0;
          2'h3:    v = 1'b1;
          default: v = oc;
        endcase
      end
    end else if (phase_m) begin
      if (match && com[1]) begin
        v = com[0] ? up : ~up;
      end
    end else begin
      if (match && com[1]) begin
        v = com[0];
      end
      if (wrap && com[1]) begin
        v = ~com[0];
      end
    end
    wave_next = v;
  endfunction : wave_next

  assign req   = cyc_i & stb_i;
  // Writes land at the edge where ack is seen high by the master
  assign wr_en = req & we_i & ack_o & sel_i[0];
  assign wbyte = dat_i[7:0];

  // Mode decode across two control registers
  assign waveform_mode_field = timer8_pkg::wave_mode_t'({timer_ctrl_b_q[`CB_WGM2_BIT],
                                                         timer_ctrl_a_q[`CA_WGM1_BIT],
                                                         timer_ctrl_a_q[`CA_WGM0_BIT]});
  assign clock_select_field  = timer8_pkg::clk_sel_t'(timer_ctrl_b_q[`CB_CS_HI:`CB_CS_LO]);
  assign com_a = timer_ctrl_a_q[`CA_COMA_HI:`CA_COMA_LO];
  assign com_b = timer_ctrl_a_q[`CA_COMB_HI:`CA_COMB_LO];
  assign pwm   = is_pwm(waveform_mode_field);
  assign phase = (waveform_mode_field == timer8_pkg::WM_PHASE_MAX) ||
                 (waveform_mode_field == timer8_pkg::WM_PHASE_OCA);

  // Top is compare A in CTC and the OCA modes, otherwise the maximum
  assign top_val = ((waveform_mode_field == timer8_pkg::WM_CTC) ||
                    (waveform_mode_field == timer8_pkg::WM_PHASE_OCA) ||
                    (waveform_mode_field == timer8_pkg::WM_FAST_OCA)) ?
                   cmp_a_q : `CNT_MAX;
  assign at_top  = (count_value_q == top_val);

  // Shared prescaler, held while the divider reset bit or its pulse is set
  assign shared_divider_reset_o = shared_divider_reset_q | div_reset_pulse_q;
  assign prescale_tap_o         = tap;

  shared_prescaler #(
    .WIDTH (10)
  ) u_prescaler (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .div_reset_i (shared_divider_reset_o),
    .tap_o       (tap)
  );

  ext_edge_sync u_ext_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (ext_count_pin_i),
    .rise_o  (ext_rise),
    .fall_o  (ext_fall),
    .level_o ()
  );

  // Tick source selection; power off gates every source
  always_comb begin
    unique case (clock_select_field)
      timer8_pkg::CS_STOP:     timer_tick = 1'b0;
      timer8_pkg::CS_DIV1:     timer_tick = 1'b1;
      timer8_pkg::CS_DIV8:     timer_tick = tap[0];
      timer8_pkg::CS_DIV64:    timer_tick = tap[1];
      timer8_pkg::CS_DIV256:   timer_tick = tap[2];
      timer8_pkg::CS_DIV1K:    timer_tick = tap[3];
      timer8_pkg::CS_EXT_FALL: timer_tick = ext_fall;
      timer8_pkg::CS_EXT_RISE: timer_tick = ext_rise;
    endcase
    if (timer_power_off_q) begin
      timer_tick = 1'b0;
    end
  end

  // Events of this tick; a pending block suppresses both matches
  assign match_a  = timer_tick & ~block_q & (count_value_q == cmp_a_q);
  assign match_b  = timer_tick & ~block_q & (count_value_q == cmp_b_q);
  assign wrap_evt = timer_tick & at_top & ~phase;
  always_comb begin
    if (!pwm) begin
      ovf_evt = timer_tick & (count_value_q == `CNT_MAX);
    end else if (phase) begin
      ovf_evt = timer_tick & (count_value_q == `CNT_BOTTOM);
    end else begin
      ovf_evt = timer_tick & at_top;
    end
  end

  // Counting sequence for the current mode
  always_comb begin
    count_up_d    = count_up_q;
    count_value_d = count_value_q;
    if (phase) begin
      if (count_up_q && at_top) begin
        count_up_d    = 1'b0;
        count_value_d = 8'(count_value_q - 8'h01);
      end else if (!count_up_q && (count_value_q == `CNT_BOTTOM)) begin
        count_up_d    = 1'b1;
        count_value_d = 8'(count_value_q + 8'h01);
      end else if (count_up_q) begin
        count_value_d = 8'(count_value_q + 8'h01);
      end else begin
        count_value_d = 8'(count_value_q - 8'h01);
      end
    end else begin
      count_up_d    = 1'b1;
      count_value_d = at_top ? `CNT_BOTTOM : 8'(count_value_q + 8'h01);
    end
  end

  // Counter: a bus write outranks the tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_value_q <= `REG_RESET;
      count_up_q    <= 1'b1;
    end else if (wr_en && (adr_i == ADDR_W'(`COUNT_OFF))) begin
      count_value_q <= wbyte;
    end else if (timer_tick) begin
      count_value_q <= count_value_d;
      count_up_q    <= count_up_d;
    end
  end

  // Match blocking after a count write, even while stopped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      block_q <= 1'b0;
    end else if (wr_en && (adr_i == ADDR_W'(`COUNT_OFF))) begin
      block_q <= 1'b1;
    end else if (timer_tick) begin
      block_q <= 1'b0;
    end
  end

  // General timer control; divider reset holds only in sync hold mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_hold_mode_q       <= 1'b0;
      capture_input_select_q <= 1'b0;
      shared_divider_reset_q <= 1'b0;
      div_reset_pulse_q      <= 1'b0;
    end else if (wr_en && (adr_i == ADDR_W'(`GTC_OFF))) begin
      sync_hold_mode_q       <= wbyte[`GTC_SYNC_BIT];
      capture_input_select_q <= wbyte[`GTC_CAPSEL_BIT];
      shared_divider_reset_q <= wbyte[`GTC_DIVRST_BIT] & wbyte[`GTC_SYNC_BIT];
      div_reset_pulse_q      <= wbyte[`GTC_DIVRST_BIT];
    end else begin
      shared_divider_reset_q <= shared_divider_reset_q & sync_hold_mode_q;
      div_reset_pulse_q      <= 1'b0;
    end
  end

  // Other control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_ctrl_a_q    <= `REG_RESET;
      timer_ctrl_b_q    <= `REG_RESET;
      timer_irq_mask_q  <= 3'h0;
      timer_power_off_q <= 1'b0;
    end else if (wr_en) begin
      if (adr_i == ADDR_W'(`CTRL_A_OFF)) begin
        timer_ctrl_a_q <= wbyte;
      end
      if (adr_i == ADDR_W'(`CTRL_B_OFF)) begin
        timer_ctrl_b_q <= {4'h0, wbyte[3:0]};
      end
      if (adr_i == ADDR_W'(`MASK_OFF)) begin
        timer_irq_mask_q <= wbyte[2:0];
      end
      if (adr_i == ADDR_W'(`POWER_OFF)) begin
        timer_power_off_q <= wbyte[`PWR_OFF_BIT];
      end
    end
  end

  // Compare values: buffered in PWM modes, loaded at top
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_a_q     <= `REG_RESET;
      cmp_b_q     <= `REG_RESET;
      cmp_a_buf_q <= `REG_RESET;
      cmp_b_buf_q <= `REG_RESET;
    end else begin
      if (wr_en && (adr_i == ADDR_W'(`CMP_A_OFF))) begin
        cmp_a_buf_q <= wbyte;
      end
      if (wr_en && (adr_i == ADDR_W'(`CMP_B_OFF))) begin
        cmp_b_buf_q <= wbyte;
      end
      if (!pwm) begin
        if (wr_en && (adr_i == ADDR_W'(`CMP_A_OFF))) begin
          cmp_a_q <= wbyte;
        end
        if (wr_en && (adr_i == ADDR_W'(`CMP_B_OFF))) begin
          cmp_b_q <= wbyte;
        end
      end else if (timer_tick && at_top) begin
        cmp_a_q <= cmp_a_buf_q;
        cmp_b_q <= cmp_b_buf_q;
      end
    end
  end

  // Flags: hardware set beats software or acknowledge clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_flag_q <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if ((wr_en && (adr_i == ADDR_W'(`FLAG_OFF)) && wbyte[i]) || irq_ack_i[i]) begin
          timer_flag_q[i] <= 1'b0;
        end
      end
      if (ovf_evt) begin
        timer_flag_q[`FLAG_OVF] <= 1'b1;
      end
      if (match_a) begin
        timer_flag_q[`FLAG_CMPA] <= 1'b1;
      end
      if (match_b) begin
        timer_flag_q[`FLAG_CMPB] <= 1'b1;
      end
    end
  end

  // Masked requests toward the interrupt controller
  assign irq_o = timer_flag_q & timer_irq_mask_q;

  // Waveform generator state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oc_a_q <= 1'b0;
      oc_b_q <= 1'b0;
    end else if (timer_tick) begin
      oc_a_q <= wave_next(com_a, pwm, phase, count_up_q, match_a, wrap_evt, oc_a_q);
      oc_b_q <= wave_next(com_b, pwm, phase, count_up_q, match_b, wrap_evt, oc_b_q);
    end
  end

  // Pin override whenever a compare output mode is set
  assign compare_out_a_o    = oc_a_q;
  assign compare_out_b_o    = oc_b_q;
  assign compare_out_a_en_o = |com_a;
  assign compare_out_b_en_o = |com_b;

  // Capture pins synchronized, then steered to the second timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_pri_meta_q    <= 1'b0;
      cap_pri_q         <= 1'b0;
      cap_alt_meta_q    <= 1'b0;
      cap_alt_q         <= 1'b0;
      capture_trigger_o <= 1'b0;
    end else begin
      cap_pri_meta_q    <= capture_pin_primary_i;
      cap_pri_q         <= cap_pri_meta_q;
      cap_alt_meta_q    <= capture_pin_alternate_i;
      cap_alt_q         <= cap_alt_meta_q;
      capture_trigger_o <= capture_input_select_q ? cap_alt_q : cap_pri_q;
    end
  end

  // Read mux; unmapped words read as zero
  always_comb begin
    unique case (adr_i)
      ADDR_W'(`GTC_OFF):    rd_val = {sync_hold_mode_q, capture_input_select_q, 5'h00,
                                      shared_divider_reset_q};
      ADDR_W'(`CTRL_A_OFF): rd_val = timer_ctrl_a_q;
      ADDR_W'(`CTRL_B_OFF): rd_val = timer_ctrl_b_q;
      ADDR_W'(`COUNT_OFF):  rd_val = count_value_q;
      ADDR_W'(`CMP_A_OFF):  rd_val = pwm ? cmp_a_buf_q : cmp_a_q;
      ADDR_W'(`CMP_B_OFF):  rd_val = pwm ? cmp_b_buf_q : cmp_b_q;
      ADDR_W'(`FLAG_OFF):   rd_val = {5'h00, timer_flag_q};
      ADDR_W'(`MASK_OFF):   rd_val = {5'h00, timer_irq_mask_q};
      ADDR_W'(`POWER_OFF):  rd_val = {7'h00, timer_power_off_q};
      default:              rd_val = 8'h00;
    endcase
  end

  // One wait state, ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & ~ack_o;
      if (req && !ack_o) begin
        dat_o <= {24'h00_0000, rd_val};
      end
    end
  end

endmodule : timer8

`default_nettype wire

// >>> verif/timer8_props.sv
`timescale 1ns/10ps
`default_nettype none

module timer8_props #(
  parameter int unsigned ADDR_W = 8
) (
  // Clock, reset and bus
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              cyc_i,
  input wire logic              stb_i,
  input wire logic              we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [31:0]       dat_i,
  input wire logic [3:0]        sel_i,
  input wire logic [31:0]       dat_o,
  input wire logic              ack_o,
  // Pins and links
  input wire logic              compare_out_a_en_o,
  input wire logic              shared_divider_reset_o,
  input wire logic [3:0]        prescale_tap_o
);
  logic gtc_wr;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Write to general control taking effect at this edge
  assign gtc_wr = ack_o && we_i && sel_i[0] && adr_i == ADDR_W'(0);

  // Bus handshake, one wait state
  ack_timing_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  unmapped_zero_a: assert property (ack_o && !we_i && adr_i == ADDR_W'(8'h24)
    |-> dat_o == 32'h0000_0000) else $error("unmapped read not zero");
  // Divider reset, tap spacing and output enable behaviour
  sync_hold_a: assert property (gtc_wr && dat_i[7] && dat_i[0] |=> shared_divider_reset_o [*2])
    else $error("divider reset not held in sync mode");
  sync_clear_a: assert property (gtc_wr && !dat_i[7] |=> ##1 !shared_divider_reset_o)
    else $error("divider reset not cleared");
  div_pulse_a: assert property (gtc_wr && !dat_i[7] && dat_i[0]
    |=> shared_divider_reset_o ##1 !shared_divider_reset_o) else $error("divider reset not a pulse");
  tap_space_a: assert property (prescale_tap_o[0] |=> !prescale_tap_o[0] [*7])
    else $error("divide by eight tap too close");
  oc_en_src_a: assert property ($changed(compare_out_a_en_o)
    |-> $past(ack_o && we_i && adr_i == ADDR_W'(8'h04))) else $error("output enable moved alone");

  // Main scenarios reached
  cover property (gtc_wr && dat_i[7] && dat_i[0]);
  cover property (gtc_wr && !dat_i[7] && dat_i[0]);
  cover property (ack_o && !we_i && adr_i == ADDR_W'(8'h24));
endmodule : timer8_props

bind timer8 timer8_props #(.ADDR_W(ADDR_W)) timer8_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
  .dat_o(dat_o), .ack_o(ack_o), .compare_out_a_en_o(compare_out_a_en_o),
  .shared_divider_reset_o(shared_divider_reset_o), .prescale_tap_o(prescale_tap_o));

`default_nettype wire

// >>> verif/timer8_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module timer8_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [3:0]  sel_i = 4'hF;
  logic        ext_pin = 1'b0;
  logic        prim = 1'b0;
  logic        alt = 1'b0;
  logic [2:0]  irq_ack = 3'h0;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        oca_en;
  logic        ocb_en;
  logic        oca;
  logic        ocb;
  logic        cap;
  logic [2:0]  irq_o;
  logic [31:0] exp_q[$];
  logic [31:0] v;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  timer8 #(.ADDR_W(8)) timer8_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_count_pin_i(ext_pin), .capture_pin_primary_i(prim), .capture_pin_alternate_i(alt),
    .compare_out_a_o(oca), .compare_out_a_en_o(oca_en), .compare_out_b_o(ocb),
    .compare_out_b_en_o(ocb_en), .shared_divider_reset_o(), .prescale_tap_o(),
    .capture_trigger_o(cap), .irq_o(irq_o), .irq_ack_i(irq_ack));

  // Free running system clock
  always #5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // Classic cycle: hold everything until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    sel_i <= 4'hF;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  // Note the expected byte, then read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h00_0000, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Slow pin pulses, each half well above one clock
  task automatic pulses(input int n);
    repeat (n) begin
      ext_pin <= 1'b1;
      repeat (4) @(posedge clk_i);
      ext_pin <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : pulses

  // Read answers matched against the oldest note
  always @(posedge clk_i) begin
    if (ack_o === 1'b1 && we_i === 1'b0) begin
      if (exp_q.size() == 0) chk(dat_o, 32'hFFFF_FFFF);
      else chk(dat_o, exp_q.pop_front());
    end
  end

  // Hang guard, well above the whole sequence
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  initial begin
    v = $urandom(32'h3110a8c5);
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h18, 8'h00);
    wr(8'h00, 32'h0000_00FF);
    rd(8'h00, 8'hC1);
    wr(8'h00, 32'h0000_0041);
    rd(8'h00, 8'h40);
    wr(8'h00, 32'h0000_0001);
    rd(8'h00, 8'h00);
    $display("test control done");
    v = $urandom;
    prim <= v[0];
    alt <= ~v[0];
    repeat (5) @(posedge clk_i);
    chk({31'h0, cap}, {31'h0, v[0]});
    wr(8'h00, 32'h0000_0040);
    repeat (5) @(posedge clk_i);
    chk({31'h0, cap}, {31'h0, ~v[0]});
    wr(8'h00, 32'h0000_0000);
    for (int i = 0; i < 3; i++) begin
      v = $urandom;
      wr(8'h0C + 8'(4 * i), v);
      rd(8'h0C + 8'(4 * i), v[7:0]);
    end
    rd(8'h24, 8'h00);
    wr(8'h08, 32'h0000_00FF);
    rd(8'h08, 8'h0F);
    wr(8'h08, 32'h0000_0000);
    $display("test registers done");
    wr(8'h10, 32'h0000_0080);
    wr(8'h14, 32'h0000_0090);
    wr(8'h0C, 32'h0000_00F0);
    wr(8'h08, 32'h0000_0001);
    repeat (20) @(posedge clk_i);
    wr(8'h08, 32'h0000_0000);
    rd(8'h18, 8'h01);
    wr(8'h18, 32'h0000_0001);
    rd(8'h18, 8'h00);
    wr(8'h0C, 32'h0000_007C);
    wr(8'h08, 32'h0000_0001);
    repeat (10) @(posedge clk_i);
    wr(8'h08, 32'h0000_0000);
    rd(8'h18, 8'h02);
    wr(8'h1C, 32'h0000_0002);
    @(negedge clk_i);
    chk({29'h0, irq_o}, 32'h0000_0002);
    @(posedge clk_i);
    irq_ack <= 3'h2;
    @(posedge clk_i);
    irq_ack <= 3'h0;
    @(negedge clk_i);
    chk({29'h0, irq_o}, 32'h0000_0000);
    rd(8'h18, 8'h00);
    $display("test flags done");
    wr(8'h0C, 32'h0000_0000);
    wr(8'h08, 32'h0000_0007);
    pulses(3);
    wr(8'h08, 32'h0000_0000);
    rd(8'h0C, 8'h03);
    wr(8'h20, 32'h0000_0001);
    wr(8'h08, 32'h0000_0007);
    pulses(2);
    wr(8'h08, 32'h0000_0000);
    wr(8'h20, 32'h0000_0000);
    rd(8'h0C, 8'h03);
    wr(8'h08, 32'h0000_0006);
    pulses(3);
    wr(8'h08, 32'h0000_0000);
    pulses(2);
    rd(8'h0C, 8'h06);
    $display("test external done");
    wr(8'h04, 32'h0000_0052);
    @(negedge clk_i);
    chk({30'h0, oca_en, ocb_en}, 32'h0000_0003);
    rd(8'h04, 8'h52);
    // Clear-on-match run: B match blocked by the count write, A toggles and clears
    wr(8'h0C, 32'h0000_007F);
    wr(8'h14, 32'h0000_007F);
    wr(8'h08, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    @(negedge clk_i);
    chk({30'h0, oca, ocb}, 32'h0000_0002);
    rd(8'h18, 8'h02);
    rd(8'h0C, 8'h01);
    // Divider held in sync mode, then released: one tick per eight clocks
    wr(8'h0C, 32'h0000_0000);
    wr(8'h00, 32'h0000_0081);
    wr(8'h08, 32'h0000_0002);
    wr(8'h00, 32'h0000_0000);
    repeat (28) @(posedge clk_i);
    wr(8'h08, 32'h0000_0000);
    rd(8'h0C, 8'h03);
    wr(8'h04, 32'h0000_0000);
    $display("test waveform done");
    wrap_up();
  end
endmodule : timer8_tb_top

`default_nettype wire
